// ---- dv/hpp_host.sv ----
// Host processor model that drives the parallel port pins.
`timescale 1ns/10ps
module hpp_host (
    input wire logic i_clk_sys,
    input wire logic [15:0] i_ad,
    input wire logic [15:0] i_ad_oe,
    output logic o_cs = 1'b0,
    output logic o_rd = 1'b0,
    output logic o_wr = 1'b0,
    output logic o_ale = 1'b0,
    output logic [4:0] o_addr = 5'h00,
    output logic [15:0] o_ad = 16'h0000
);
    logic rw = 1'b0;
    logic cs_on = 1'b1;
    logic [15:0] rd_q;
    logic [15:0] rd_oe;
    // One strobe of ten cycles, then six idle; read data taken at the last strobe edge.
    task automatic cyc(input logic w, input logic [4:0] a, input logic [15:0] d);
        @(posedge i_clk_sys);
        o_addr <= a;
        o_ad <= w ? d : ~o_ad;
        o_cs <= cs_on;
        o_rd <= rw ? w : !w;
        o_wr <= rw | w;
        repeat (10) @(posedge i_clk_sys);
        rd_q = i_ad;
        rd_oe = i_ad_oe;
        o_cs <= !cs_on;
        o_rd <= 1'b0;
        o_wr <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        o_ad <= ~o_ad;
        repeat (2) @(posedge i_clk_sys);
    endtask
    // Single phase latch of the full address, upper lane kept afterwards.
    task automatic latch(input logic [15:0] a);
        @(posedge i_clk_sys);
        o_ale <= 1'b1;
        o_ad <= a;
        repeat (6) @(posedge i_clk_sys);
        o_ale <= 1'b0;
        repeat (6) @(posedge i_clk_sys);
        o_ad <= {a[15:8], ~a[7:0]};
    endtask
endmodule // hpp_host

// ---- dv/parallel_host_bus_access_bench.sv ----
// Randomised self-checking bench for the parallel host port.
`timescale 1ns/10ps
module parallel_host_bus_access_bench;
    import hpp_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cs, rd, wr, ale, wt, int_wr, int_rd;
    logic [4:0] addr;
    logic [15:0] ad_h, ad_d, oe, int_addr, wa;
    logic [31:0] int_wdata, cfg, wd;
    logic [31:0] int_rdata;
    logic wide = 1'b1;
    logic be = 1'b0;
    int seed = 32'h2af8;
    int err_count = 0;
    int tests_run = 0;
    int wr_n = 0;
    int rd_n = 0;
    always #20 clk = ~clk;
    hpp_host host (.i_clk_sys(clk), .i_ad(ad_d), .i_ad_oe(oe), .o_cs(cs), .o_rd(rd),
        .o_wr(wr), .o_ale(ale), .o_addr(addr), .o_ad(ad_h));
    hpp_port dut (.i_clk_sys(clk), .i_reset(rst), .i_clk_en(1'b1), .i_cs(cs), .i_rd(rd),
        .i_wr(wr), .i_ale(ale), .i_addr(addr), .i_ad(ad_h), .o_ad(ad_d), .o_ad_oe(oe),
        .o_wait(wt), .o_int_wr(int_wr), .o_int_rd(int_rd), .o_int_addr(int_addr),
        .o_int_wdata(int_wdata), .i_int_rdata(int_rdata), .o_cfg(cfg));
    function automatic logic [31:0] rdm(input logic [15:0] a);
        return {a, ~a} ^ 32'h5a5a_0f0f;
    endfunction
    function automatic logic [15:0] sw(input logic [15:0] x);
        return be ? {x[7:0], x[15:8]} : x;
    endfunction
    always @* int_rdata = rdm(int_addr);
    always @(posedge clk) begin
        if (int_wr === 1'b1) begin
            wr_n <= wr_n + 1;
            wa <= int_addr;
            wd <= int_wdata;
        end
        if (int_rd === 1'b1) rd_n <= rd_n + 1;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic do_reset;
        rst <= 1'b1;
        host.o_cs <= 1'b0;
        host.rw = 1'b0;
        host.cs_on = 1'b1;
        wide = 1'b1;
        be = 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
    endtask
    task automatic setcfg(input logic [15:0] v);
        host.cyc(1'b1, HPP_CFG_ADDR, wide ? sw(v) : v);
        be = v[HPP_CFG_BIGEND];
        wide = v[HPP_CFG_WIDE];
        check(cfg, {16'h0, v});
    endtask
    task automatic xfer(input logic w, input logic [4:0] a, inout logic [31:0] v);
        logic [15:0] pv;
        for (int p = 0; p < 4; p += (wide ? 2 : 1)) begin
            pv = 16'(v >> (8 * p));
            if (!wide) pv[15:8] = 8'($random(seed));
            host.cyc(w, a + 5'(p), wide ? sw(pv) : pv);
            if (!w) begin
                check(host.rd_oe, wide ? 16'hffff : 16'h00ff);
                if (wide) v[8*p +: 16] = sw(host.rd_q);
                else v[8*p +: 8] = host.rd_q[7:0];
            end
        end
    endtask
    task automatic pair(input int k);
        logic [31:0] v, e, d;
        logic [4:0] ia;
        int n;
        ia = HPP_IDX0_ADDR + 5'(k) * HPP_PAIR_STRIDE;
        v = $random(seed);
        d = $random(seed);
        e = ~v;
        xfer(1'b1, ia, v);
        xfer(1'b0, ia, e);
        check(e[23:0], v[23:0]);
        n = wr_n;
        xfer(1'b1, ia + 5'h4, d);
        check(wr_n, n + 1);
        check(wa, v[15:0]);
        check(wd, d);
        xfer(1'b0, ia + 5'h4, e);
        check(e, rdm(v[15:0]));
        check(oe, 16'h0);
    endtask
    task automatic mux;
        logic [15:0] a;
        logic [31:0] d, e;
        int n;
        a = 16'($random(seed)) & 16'hfffc;
        d = $random(seed);
        e = rdm(a);
        n = wr_n;
        for (int b = 0; b < 4; b++) begin
            host.latch(a + 16'(b));
            host.cyc(1'b1, 5'h0, {a[15:8], d[8*b +: 8]});
        end
        check(wr_n, n + 1);
        check(wa, a);
        check(wd, d);
        n = rd_n;
        host.latch(a);
        host.cyc(1'b0, 5'h0, 16'h0);
        host.cyc(1'b0, 5'h0, 16'h0);
        check(host.rd_q[7:0], e[7:0]);
        check(host.rd_oe, 16'h00ff);
        check(rd_n, n + 2);
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        wrap_up;
    end
    initial begin
        do_reset;
        @(posedge clk);
        check(cfg, HPP_CFG_RESET);
        check(wt, 1'b1);
        check(oe, 16'h0);
        host.cyc(1'b0, HPP_CFG_ADDR, 16'h0);
        check(host.rd_q, 16'h004e);
        for (int k = 0; k < HPP_IDX_N; k++) pair(k);
        setcfg(16'h006e);
        be = 1'b1;
        pair(1);
        setcfg(16'h004f);
        host.rw = 1'b1;
        pair(2);
        setcfg(16'h0047);
        host.cs_on = 1'b0;
        pair(0);
        do_reset;
        setcfg(16'h000e);
        wide = 1'b0;
        pair(0);
        pair(2);
        do_reset;
        setcfg(16'h008e);
        wide = 1'b0;
        mux;
        wrap_up;
    end
endmodule // parallel_host_bus_access_bench

// ---- rtl/hpp_pkg.sv ----
// Package of constants and types for the parallel host port.
package hpp_pkg;
    localparam int HPP_DATA_W = 16;
    localparam int HPP_ADDR_W = 16;
    localparam int HPP_IDX_N = 3;
    // Indexed mode layout, byte addresses on the host bus.
    localparam logic [4:0] HPP_CFG_ADDR = 5'h00;
    localparam logic [4:0] HPP_IDX0_ADDR = 5'h04;
    localparam logic [4:0] HPP_DAT0_ADDR = 5'h08;
    localparam logic [4:0] HPP_PAIR_STRIDE = 5'h08;
    // Configuration register fields.
    localparam int HPP_CFG_RWMODE = 0;
    localparam int HPP_CFG_RDPOL = 1;
    localparam int HPP_CFG_WRPOL = 2;
    localparam int HPP_CFG_CSPOL = 3;
    localparam int HPP_CFG_WAITPOL = 4;
    localparam int HPP_CFG_BIGEND = 5;
    localparam int HPP_CFG_WIDE = 6;
    localparam int HPP_CFG_MUX = 7;
    // Read polarity high, write/enable polarity high, select high, wait low, 16-bit.
    localparam logic [31:0] HPP_CFG_RESET = 32'h0000_004e;
    localparam logic [31:0] HPP_IDX_RESET = 32'h0000_0000;
    localparam logic [1:0] HPP_SYNC_STAGES = 2'h2;

    typedef struct packed {
        logic rd;
        logic wr;
        logic cs;
        logic ale;
    } hpp_strobe_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } hpp_req_t;
endpackage

// ---- rtl/hpp_port.sv ----
// Parallel host port slave: multiplexed 8-bit single phase and indexed modes.
`timescale 1ns/10ps
// Notes on behaviour
// - Single phase latch takes both address lanes.
// - Upper lane ignored and undriven in 8-bit data.
// - Mode bit selects split or direction/enable strobes.
// - Direction/enable works identically in all variants.
// - Default enable active high, direction high writes.
// - Wait, select, read, write polarities configurable.
// - Endian bit swaps bytes, in 16-bit data only.
// - Write data taken at trailing strobe edge.
// - Read data driven only during read strobe.
// - 8-bit indexed uses low lane only.
// - Config and index accesses may be partial.
// - Index top byte reserved, writes ignored.
// - Any read/write mix through one index.
// - Skipped latch reuses last address.
module hpp_port #(
    parameter int IDX_N = hpp_pkg::HPP_IDX_N
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_clk_en,
    input wire logic i_cs,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic i_ale,
    input wire logic [4:0] i_addr,
    input wire logic [15:0] i_ad,
    output logic [15:0] o_ad,
    output logic [15:0] o_ad_oe,
    output logic o_wait,
    output logic o_int_wr,
    output logic o_int_rd,
    output logic [15:0] o_int_addr,
    output logic [31:0] o_int_wdata,
    input wire logic [31:0] i_int_rdata,
    output logic [31:0] o_cfg
);
    import hpp_pkg::*;

    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic [3:0] s3_q;
    logic [15:0] ad1_q;
    logic [15:0] ad2_q;
    logic [4:0] a1_q;
    logic [4:0] a2_q;
    logic [31:0] cfg_q;
    logic [31:0] idx_q [IDX_N];
    logic [31:0] hold_q;
    logic [31:0] rdbuf_q;
    logic [15:0] maddr_q;
    logic [15:0] dout_q;
    logic int_wr_q;
    logic int_rd_q;
    logic [15:0] int_addr_q;
    logic [31:0] int_wdata_q;

    function automatic logic [31:0] swap16(input logic [31:0] v, input logic be);
        swap16 = be ? {v[23:16], v[31:24], v[7:0], v[15:8]} : v;
    endfunction

    // Raw strobe decode with programmable polarities.
    wire rw_mode = cfg_q[HPP_CFG_RWMODE];
    // Decoding reads only the second synchroniser stage of the pins.
    wire en_act = s2_q[2] ~^ cfg_q[HPP_CFG_WRPOL];
    wire rdpin_act = s2_q[1] ~^ cfg_q[HPP_CFG_RDPOL];
    wire cs_act = s2_q[0] ~^ cfg_q[HPP_CFG_CSPOL];
    // Direction on the read pin: with the default polarity a high level is a write.
    wire dir_wr = s2_q[1] ~^ cfg_q[HPP_CFG_RDPOL];
    wire raw_rd = cs_act & (rw_mode ? (en_act & ~dir_wr) : rdpin_act);
    wire raw_wr = cs_act & (rw_mode ? (en_act & dir_wr) : en_act);
    wire raw_ale = s2_q[3];

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            ad1_q <= '0;
            ad2_q <= '0;
            a1_q <= '0;
            a2_q <= '0;
        end else if (i_clk_en) begin
            s1_q <= {i_ale, i_wr, i_rd, i_cs};
            s2_q <= s1_q;
            s3_q <= {raw_ale, raw_wr, raw_rd, cs_act};
            ad1_q <= i_ad;
            ad2_q <= ad1_q;
            a1_q <= i_addr;
            a2_q <= a1_q;
        end
    end

    wire rd_act = raw_rd;
    wire rd_rise = raw_rd & ~s3_q[1];
    wire wr_fall = ~raw_wr & s3_q[2];
    wire ale_fall = ~raw_ale & s3_q[3];
    wire wide = cfg_q[HPP_CFG_WIDE];
    wire mux = cfg_q[HPP_CFG_MUX];
    wire be = cfg_q[HPP_CFG_BIGEND];

    // Effective byte address of this cycle.
    wire [4:0] ix_addr = a2_q;
    wire [15:0] eff_addr = mux ? maddr_q : {11'h000, ix_addr};
    wire [1:0] lane = wide ? {eff_addr[1], 1'b0} : eff_addr[1:0];
    wire [31:0] wmask = wide ? (32'h0000_ffff << {lane, 3'h0}) : (32'h0000_00ff << {lane, 3'h0});
    // 8-bit cycles take only the low lane.
    wire [15:0] wlane = wide ? ad2_q : {8'h00, ad2_q[7:0]};
    wire [31:0] wrep = swap16({wlane, wlane}, be & wide);
    wire [31:0] wshift = wide ? wrep : {4{wlane[7:0]}};
    wire last_part = wide ? lane[1] : (lane == 2'h3);

    // Target decode in indexed mode.
    wire is_cfg = ~mux & (ix_addr[4:2] == HPP_CFG_ADDR[4:2]);
    wire [2:0] pair = 3'(ix_addr[4:3]);
    wire is_idx = ~mux & ix_addr[2] & (32'(pair) < IDX_N);
    wire is_dat = ~mux & ~is_cfg & ~ix_addr[2] & (32'(pair) <= IDX_N);
    wire [1:0] psel = is_dat ? 2'(pair - 3'h1) : 2'(pair);
    wire [15:0] tgt_addr = mux ? {maddr_q[15:2], 2'h0} : idx_q[psel][15:0];
    wire to_int = mux | is_dat;
    wire [31:0] rsrc = is_cfg ? cfg_q : (is_idx ? idx_q[psel] : rdbuf_q);
    wire [31:0] rsw = swap16(rsrc, be & wide);
    wire [15:0] rword = wide ? (lane[1] ? rsw[31:16] : rsw[15:0])
        : {8'h00, rsrc[{lane, 3'h0} +: 8]};

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            cfg_q <= HPP_CFG_RESET;
            for (int i = 0; i < IDX_N; i++) begin
                idx_q[i] <= HPP_IDX_RESET;
            end
            hold_q <= '0;
            rdbuf_q <= '0;
            maddr_q <= '0;
            dout_q <= '0;
            int_wr_q <= 1'b0;
            int_rd_q <= 1'b0;
            int_addr_q <= '0;
            int_wdata_q <= '0;
        end else if (i_clk_en) begin
            int_wr_q <= 1'b0;
            int_rd_q <= 1'b0;
            if (ale_fall && mux) begin
                maddr_q <= ad2_q;
            end
            if (wr_fall && is_cfg) begin
                cfg_q <= (cfg_q & ~wmask) | (wshift & wmask);
            end
            if (wr_fall && is_idx) begin
                idx_q[psel] <= ((idx_q[psel] & ~wmask) | (wshift & wmask)) & 32'h00ff_ffff;
            end
            if (wr_fall && to_int) begin
                hold_q <= (hold_q & ~wmask) | (wshift & wmask);
                if (last_part) begin
                    int_wr_q <= 1'b1;
                    int_addr_q <= tgt_addr;
                    int_wdata_q <= (hold_q & ~wmask) | (wshift & wmask);
                end
            end
            if (rd_rise && to_int && lane == 2'h0) begin
                int_rd_q <= 1'b1;
                int_addr_q <= tgt_addr;
            end
            if (int_rd_q) begin
                rdbuf_q <= i_int_rdata;
            end
            dout_q <= rword;
        end
    end

    // The bus is driven only while the synchronised read strobe is active.
    assign o_ad = dout_q;
    assign o_ad_oe = (rd_act && !int_rd_q) ? (wide ? 16'hffff : 16'h00ff) : 16'h0000;
    // Wait is asserted while a read fetch is outstanding.
    assign o_wait = (rd_act & int_rd_q) ^ ~cfg_q[HPP_CFG_WAITPOL];
    assign o_int_wr = int_wr_q;
    assign o_int_rd = int_rd_q;
    assign o_int_addr = int_addr_q;
    assign o_int_wdata = int_wdata_q;
    assign o_cfg = cfg_q;

    wr_pulse_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        o_int_wr |=> !o_int_wr) else $error("internal write longer than one cycle");
    wr_commit_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && wr_fall && to_int && last_part) |=> o_int_wr)
        else $error("last part did not commit");
    wr_partial_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && wr_fall && !last_part && !s3_q[1]) |=> !o_int_wr)
        else $error("partial part committed");
    rd_drive_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !rd_act |-> o_ad_oe == 16'h0000) else $error("bus driven outside read");
    upper_lane_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !wide |-> o_ad_oe[15:8] == 8'h00) else $error("upper lane driven in 8-bit");
    idx_top_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        idx_q[0][31:24] == 8'h00) else $error("index top byte written");
    cfg_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && !wr_fall) |=> $stable(cfg_q)) else $error("config changed without write");
    latch_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && mux && ale_fall) |=> maddr_q == $past(ad2_q))
        else $error("address not latched");
    keep_addr_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !ale_fall |=> $stable(maddr_q)) else $error("address lost without latch");
    rd_fetch_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_clk_en && rd_rise && to_int && lane == 2'h0) |=> o_int_rd)
        else $error("read fetch missing");

    c_wr_c: cover property (@(posedge i_clk_sys) o_int_wr);
    c_rd_c: cover property (@(posedge i_clk_sys) o_int_rd);
    c_mux_c: cover property (@(posedge i_clk_sys) mux && ale_fall);
    c_rw_c: cover property (@(posedge i_clk_sys) rw_mode && wr_fall);
endmodule // hpp_port
